// ### design/console_pkg.sv
// Constants for the operator-console control block
package console_pkg;
    // Control codes shown on the three-bit indicator
    localparam logic [2:0] CODE_H     = 3'h0;
    localparam logic [2:0] CODE_I     = 3'h1;
    localparam logic [2:0] CODE_J     = 3'h2;
    localparam logic [2:0] CODE_K     = 3'h3;
    localparam logic [2:0] CODE_L     = 3'h4;
    localparam logic [2:0] CODE_M     = 3'h5;
    localparam logic [2:0] CODE_N     = 3'h6;
    localparam logic [2:0] CODE_ERROR = 3'h7;
    // Function control register bits, bit 0 is least significant
    localparam int AUTO_DISPLAY_ENABLE_BIT    = 10;
    localparam int CONSOLE_ECHO_ENABLE_BIT    = 11;
    localparam int BREAK_TYPE_LOW_BIT         = 16;
    localparam int BREAK_TYPE_HIGH_BIT        = 17;
    localparam int BREAK_INTERRUPT_SELECT_BIT = 18;
    localparam int MICRO_BREAK_SELECT_BIT     = 19;
    localparam int STATUS_LSB                 = 0;
    localparam int STATUS_MSB                 = 7;
    localparam logic [31:0] FUNCTION_CONTROL_RESET = 32'h0000_0000;
    // Break type field values
    localparam logic [1:0] BREAK_OFF     = 2'h0;
    localparam logic [1:0] BREAK_INSTR   = 2'h1;
    localparam logic [1:0] BREAK_OPERAND = 2'h2;
    localparam logic [1:0] BREAK_ALL     = 2'h3;
    // Master-clear pulse length in cycles
    localparam logic [3:0] CLEAR_PULSE_CYCLES = 4'h8;
    // Serial command characters
    localparam logic [7:0] ASCII_H     = 8'h48;
    localparam logic [7:0] ASCII_N     = 8'h4e;
    localparam logic [7:0] ASCII_0     = 8'h30;
    localparam logic [7:0] ASCII_9     = 8'h39;
    localparam logic [7:0] ASCII_A     = 8'h41;
    localparam logic [7:0] ASCII_F     = 8'h46;
    localparam logic [7:0] ASCII_COLON = 8'h3a;
    localparam logic [7:0] ASCII_G     = 8'h47;
    localparam logic [7:0] ASCII_AT    = 8'h40;
endpackage

// ### design/breakpoint_console_control.sv
// Operator-console command entry, function control register and breakpoint logic
`timescale 1ns/1ns
module breakpoint_console_control (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        remote_select,
    input  wire logic [15:0] hex_keys,
    input  wire logic [7:0]  control_keys,
    input  wire logic        master_clear_key,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_char,
    input  wire logic [7:0]  processor_status,
    input  wire logic [31:0] selected_value,
    input  wire logic [15:0] macro_address,
    input  wire logic        ref_instruction,
    input  wire logic        ref_operand,
    input  wire logic        micro_break_hit,
    output logic [2:0]       control_code,
    output logic             upper_lit,
    output logic [15:0]      data_display,
    output logic [31:0]      function_control,
    output logic [7:0]       display_select,
    output logic [15:0]      machine_modes,
    output logic             command_strobe,
    output logic [2:0]       command_code,
    output logic [31:0]      command_data,
    output logic             master_clear,
    output logic             break_stop,
    output logic             break_interrupt
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DIGITS,
        ST_ERROR
    } entry_state_t;

    entry_state_t entry_reg;
    logic [31:0]  function_control_reg;
    logic [31:0]  entry_data_reg;
    logic [2:0]   entry_code_reg;
    logic [2:0]   control_code_reg;
    logic         upper_reg;
    logic [15:0]  data_display_reg;
    logic         strobe_reg;
    logic [2:0]   command_code_reg;
    logic [31:0]  command_data_reg;
    logic [3:0]   clear_count_reg;
    logic         clear_key_prev_reg;
    logic [15:0]  breakpoint_reg;
    logic         stop_reg;
    logic         interrupt_reg;

    // Active key or character for this cycle, one source only
    logic        hex_event;
    logic [3:0]  hex_value;
    logic        ctl_event;
    logic [2:0]  ctl_value;
    logic        term_event;
    logic        bad_event;
    logic        in_clear;

    function automatic logic [4:0] key_index16(input logic [15:0] k);
        logic [4:0] r;
        r = 5'h10;
        for (int i = 15; i >= 0; i--)
            if (k[i])
                r = 5'(i);
        return r;
    endfunction

    assign in_clear = (clear_count_reg != 4'h0);

    always_comb
    begin
        logic [4:0] idx;
        idx        = key_index16(hex_keys);
        hex_event  = 1'b0;
        hex_value  = 4'h0;
        ctl_event  = 1'b0;
        ctl_value  = 3'h0;
        term_event = 1'b0;
        bad_event  = 1'b0;
        if (remote_select)
        begin
            // Remote serial ASCII only; panel keys ignored
            if (rx_valid)
            begin
                if (rx_char >= console_pkg::ASCII_0 && rx_char <= console_pkg::ASCII_9)
                begin
                    hex_event = 1'b1;
                    hex_value = 4'(rx_char - console_pkg::ASCII_0);
                end
                else if (rx_char >= console_pkg::ASCII_A && rx_char <= console_pkg::ASCII_F)
                begin
                    hex_event = 1'b1;
                    hex_value = 4'(rx_char - console_pkg::ASCII_A + 8'h0a);
                end
                else if (rx_char >= console_pkg::ASCII_H && rx_char <= console_pkg::ASCII_N)
                begin
                    ctl_event = 1'b1;
                    ctl_value = 3'(rx_char - console_pkg::ASCII_H);
                end
                else if (rx_char == console_pkg::ASCII_COLON || rx_char == console_pkg::ASCII_G
                         || rx_char == console_pkg::ASCII_AT)
                    term_event = 1'b1;
                else
                    bad_event = 1'b1;
            end
        end
        else
        begin
            // Local panel keys; control key has priority over hex
            if (control_keys[7])
                term_event = 1'b1;
            else if (control_keys[6:0] != 7'h00)
            begin
                ctl_event = 1'b1;
                for (int i = 6; i >= 0; i--)
                    if (control_keys[i])
                        ctl_value = 3'(i);
            end
            else if (!idx[4])
            begin
                hex_event = 1'b1;
                hex_value = idx[3:0];
            end
        end
    end

    // Master clear pulse on key press edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            clear_count_reg    <= 4'h0;
            clear_key_prev_reg <= 1'b0;
        end
        else
        begin
            clear_key_prev_reg <= master_clear_key;
            if (master_clear_key && !clear_key_prev_reg)
                clear_count_reg <= console_pkg::CLEAR_PULSE_CYCLES;
            else if (in_clear)
                clear_count_reg <= clear_count_reg - 4'h1;
        end
    end

    // Command entry: letter, hex digits, terminator, in keyed order
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || in_clear)
        begin
            entry_reg        <= ST_IDLE;
            entry_data_reg   <= 32'h0000_0000;
            entry_code_reg   <= console_pkg::CODE_H;
            strobe_reg       <= 1'b0;
            command_code_reg <= console_pkg::CODE_H;
            command_data_reg <= 32'h0000_0000;
            control_code_reg <= console_pkg::CODE_H;
        end
        else
        begin
            strobe_reg <= 1'b0;
            if (ctl_event)
            begin
                entry_reg        <= ST_DIGITS;
                entry_code_reg   <= ctl_value;
                entry_data_reg   <= 32'h0000_0000;
                control_code_reg <= ctl_value;
            end
            else if (bad_event)
            begin
                entry_reg        <= ST_ERROR;
                control_code_reg <= console_pkg::CODE_ERROR;
            end
            else
            begin
                case (entry_reg)
                    ST_IDLE:
                    begin
                        if (hex_event)
                        begin
                            entry_reg        <= ST_ERROR;
                            control_code_reg <= console_pkg::CODE_ERROR;
                        end
                    end
                    ST_DIGITS:
                    begin
                        if (hex_event)
                            entry_data_reg <= {entry_data_reg[27:0], hex_value};
                        else if (term_event)
                        begin
                            strobe_reg       <= 1'b1;
                            command_code_reg <= entry_code_reg;
                            command_data_reg <= entry_data_reg;
                            entry_reg        <= ST_IDLE;
                        end
                    end
                    ST_ERROR:
                    begin
                        // Stays in error until a new control letter arrives
                    end
                    default:
                        entry_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Function control register; write on J command, status from processor
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            function_control_reg <= console_pkg::FUNCTION_CONTROL_RESET;
        else
        begin
            if (strobe_reg && command_code_reg == console_pkg::CODE_J)
            begin
                function_control_reg <= command_data_reg;
                // Echo wins if both asked for, so the pair never coexists
                if (command_data_reg[console_pkg::AUTO_DISPLAY_ENABLE_BIT]
                    && command_data_reg[console_pkg::CONSOLE_ECHO_ENABLE_BIT])
                    function_control_reg[console_pkg::AUTO_DISPLAY_ENABLE_BIT] <= 1'b0;
            end
            // Status digits always track the processor
            function_control_reg[console_pkg::STATUS_MSB:console_pkg::STATUS_LSB]
                <= processor_status;
        end
    end

    // Display: I toggles halves, H/K/L capture the selected register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            upper_reg        <= 1'b0;
            data_display_reg <= 16'h0000;
            breakpoint_reg   <= 16'h0000;
        end
        else if (strobe_reg)
        begin
            case (command_code_reg)
                console_pkg::CODE_I:
                begin
                    upper_reg        <= !upper_reg;
                    data_display_reg <= upper_reg ? selected_value[15:0] : selected_value[31:16];
                end
                console_pkg::CODE_K, console_pkg::CODE_L, console_pkg::CODE_H:
                    data_display_reg <= upper_reg ? selected_value[31:16]
                                                  : selected_value[15:0];
                console_pkg::CODE_M:
                    breakpoint_reg <= command_data_reg[15:0];
                default:
                    data_display_reg <= data_display_reg;
            endcase
        end
    end

    // Breakpoint detection; micro vs macro, stop vs interrupt
    always_ff @(posedge ref_clk)
    begin
        logic [1:0] kind;
        logic       hit;
        kind = {function_control_reg[console_pkg::BREAK_TYPE_HIGH_BIT],
                function_control_reg[console_pkg::BREAK_TYPE_LOW_BIT]};
        hit  = 1'b0;
        if (function_control_reg[console_pkg::MICRO_BREAK_SELECT_BIT])
            hit = (kind != console_pkg::BREAK_OFF) && micro_break_hit;
        else if (macro_address == breakpoint_reg)
            hit = (kind == console_pkg::BREAK_INSTR && ref_instruction)
                || (kind == console_pkg::BREAK_OPERAND && ref_operand)
                || (kind == console_pkg::BREAK_ALL && (ref_instruction || ref_operand));
        if (!rst_n || in_clear)
        begin
            stop_reg      <= 1'b0;
            interrupt_reg <= 1'b0;
        end
        else
        begin
            interrupt_reg <= hit && function_control_reg[console_pkg::BREAK_INTERRUPT_SELECT_BIT];
            if (hit && !function_control_reg[console_pkg::BREAK_INTERRUPT_SELECT_BIT])
                stop_reg <= 1'b1;
            else if (strobe_reg)
                stop_reg <= 1'b0;
        end
    end

    assign control_code     = control_code_reg;
    assign upper_lit        = upper_reg;
    assign data_display     = data_display_reg;
    assign function_control = function_control_reg;
    assign display_select   = function_control_reg[31:24];
    assign machine_modes    = function_control_reg[23:8];
    assign command_strobe   = strobe_reg;
    assign command_code     = command_code_reg;
    assign command_data     = command_data_reg;
    assign master_clear     = in_clear;
    assign break_stop       = stop_reg;
    assign break_interrupt  = interrupt_reg;

endmodule

// ### testbench/console_sva.sv
// Port-level assertions for the console control block
`timescale 1ns/1ns
module console_sva (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        remote_select,
    input wire logic [7:0]  control_keys,
    input wire logic        rx_valid,
    input wire logic [7:0]  processor_status,
    input wire logic [2:0]  control_code,
    input wire logic [31:0] function_control,
    input wire logic [7:0]  display_select,
    input wire logic [15:0] machine_modes,
    input wire logic        command_strobe,
    input wire logic        master_clear,
    input wire logic        break_stop,
    input wire logic        break_interrupt
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic [2:0] key_idx;
    always_comb
    begin
        key_idx = 3'h0;
        for (int i = 0; i < 7; i++)
        begin
            if (control_keys[i])
                key_idx = i[2:0];
        end
    end
    property p_letter;
        !remote_select && !master_clear && $onehot(control_keys) && !control_keys[7]
            |=> control_code == $past(key_idx);
    endproperty
    a_letter: assert property (p_letter) else $error("letter code wrong");
    property p_remote;
        remote_select && !rx_valid && !master_clear |=> $stable(control_code);
    endproperty
    a_remote: assert property (p_remote) else $error("panel key taken in remote");
    property p_clear_len;
        $rose(master_clear) |-> master_clear[*8] ##1 !master_clear;
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear length wrong");
    property p_clear_block;
        master_clear && $past(master_clear) |-> !command_strobe;
    endproperty
    a_clear_block: assert property (p_clear_block) else $error("strobe in clear");
    property p_view;
        display_select == function_control[31:24] && machine_modes == function_control[23:8];
    endproperty
    a_view: assert property (p_view) else $error("digit fields wrong");
    property p_status;
        $past(rst_n) |-> function_control[7:0] == $past(processor_status);
    endproperty
    a_status: assert property (p_status) else $error("status digits wrong");
    property p_excl;
        !(function_control[10] && function_control[11]);
    endproperty
    a_excl: assert property (p_excl) else $error("echo and auto both set");
    property p_stop;
        $rose(break_stop) |-> !$past(function_control[18]);
    endproperty
    a_stop: assert property (p_stop) else $error("stop with interrupt bit");
    property p_int;
        break_interrupt |-> $past(function_control[18]);
    endproperty
    a_int: assert property (p_int) else $error("interrupt without bit");
endmodule
bind breakpoint_console_control console_sva console_sva_inst (
    .ref_clk, .rst_n, .remote_select, .control_keys, .rx_valid, .processor_status,
    .control_code, .function_control, .display_select, .machine_modes,
    .command_strobe, .master_clear, .break_stop, .break_interrupt
);

// ### testbench/panel_model.sv
// Key panel and serial console stand-in
`timescale 1ns/1ns
module panel_model (
    input  wire logic   ref_clk,
    output logic [15:0] hex_keys,
    output logic [7:0]  control_keys,
    output logic        rx_valid,
    output logic [7:0]  rx_char
);
    initial
    begin
        hex_keys = 16'h0000;
        control_keys = 8'h00;
        rx_valid = 1'b0;
        rx_char = 8'h00;
    end
    // One key for one cycle, in written order
    task automatic press(input logic [15:0] hex, input logic [7:0] ctl);
        @(negedge ref_clk);
        hex_keys = hex;
        control_keys = ctl;
        @(negedge ref_clk);
        hex_keys = 16'h0000;
        control_keys = 8'h00;
    endtask
    // Idle data inverted so a stale char never looks valid
    task automatic send(input logic [7:0] c);
        @(negedge ref_clk);
        rx_valid = 1'b1;
        rx_char = c;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_char = ~c;
    endtask
endmodule

// ### testbench/breakpoint_console_control_bench.sv
// Self-checking bench for the console control block
`timescale 1ns/1ns
module breakpoint_console_control_bench;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        remote_select = 1'b0;
    logic        master_clear_key = 1'b0;
    logic [7:0]  processor_status = 8'h5a;
    logic [31:0] selected_value = 32'hc3a5_1e69;
    logic [15:0] macro_address = 16'h0000;
    logic        ref_instruction = 1'b0;
    logic        ref_operand = 1'b0;
    logic        micro_break_hit = 1'b0;
    logic [15:0] hex_keys;
    logic [7:0]  control_keys;
    logic        rx_valid;
    logic [7:0]  rx_char;
    logic [2:0]  control_code;
    logic        upper_lit;
    logic [15:0] data_display;
    logic [31:0] function_control;
    logic [7:0]  display_select;
    logic [15:0] machine_modes;
    logic        command_strobe;
    logic [2:0]  command_code;
    logic [31:0] command_data;
    logic        master_clear;
    logic        break_stop;
    logic        break_interrupt;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          clear_cnt = 0;
    int          int_cnt = 0;
    breakpoint_console_control breakpoint_console_control_inst (
        .ref_clk, .rst_n, .remote_select, .hex_keys, .control_keys, .master_clear_key,
        .rx_valid, .rx_char, .processor_status, .selected_value, .macro_address,
        .ref_instruction, .ref_operand, .micro_break_hit, .control_code, .upper_lit,
        .data_display, .function_control, .display_select, .machine_modes,
        .command_strobe, .command_code, .command_data, .master_clear, .break_stop,
        .break_interrupt
    );
    panel_model panel_model_inst (.ref_clk, .hex_keys, .control_keys, .rx_valid, .rx_char);
    always #10 ref_clk = ~ref_clk;
    // Ceiling well above the few hundred cycles the run needs
    // Sampled on the falling edge so registered outputs have settled
    always @(negedge ref_clk)
    begin
        cycles++;
        clear_cnt += master_clear;
        int_cnt += break_interrupt;
        if (cycles == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task automatic final_report();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    // Letter, digits first-is-highest, terminator; strobe one cycle later
    task automatic cmd(input int l, input logic [31:0] v, input int nd);
        panel_model_inst.press(16'h0000, 8'h01 << l);
        chk("control_code", l, control_code);
        for (int i = nd - 1; i >= 0; i--)
            panel_model_inst.press(16'h0001 << v[4*i+:4], 8'h00);
        panel_model_inst.press(16'h0000, 8'h80);
        chk("strobe_code", {1'b1, l[2:0]}, {command_strobe, command_code});
        if (nd > 0)
            chk("command_data", v, command_data);
    endtask
    task automatic t_fc();
        chk("fc_reset", {24'h0, processor_status}, function_control);
        cmd(2, 32'h0123_4567, 8);
        @(negedge ref_clk);
        chk("fc", {24'h012345, processor_status}, function_control);
        processor_status = 8'ha5;
        cmd(2, 32'h89ab_cdef, 8);
        @(negedge ref_clk);
        chk("fc_excl", {24'h89abc9, 8'ha5}, function_control);
        chk("fields", 32'h89abc9, {display_select, machine_modes});
    endtask
    task automatic t_display();
        cmd(4, 32'h0, 0);
        @(negedge ref_clk);
        chk("lower", {15'h0, 1'b0, selected_value[15:0]}, {upper_lit, data_display});
        cmd(1, 32'h0, 0);
        @(negedge ref_clk);
        chk("upper", {15'h0, 1'b1, selected_value[31:16]}, {upper_lit, data_display});
        selected_value = 32'h5e17_0c0d;
        for (int l = 0; l < 4; l += 3)
        begin
            cmd(l, 32'h0, 0);
            @(negedge ref_clk);
            chk("capture", selected_value[31:16], data_display);
        end
        panel_model_inst.press(16'h0000, 8'h40);
        chk("code_n", 3'h6, control_code);
    endtask
    task automatic t_remote();
        @(negedge ref_clk);
        remote_select = 1'b1;
        panel_model_inst.press(16'h0000, 8'h08);
        chk("panel_ignored", 3'h6, control_code);
        panel_model_inst.send(8'h5a);
        chk("bad_char", console_pkg::CODE_ERROR, control_code);
        panel_model_inst.send(8'h4c);
        panel_model_inst.send(console_pkg::ASCII_COLON);
        chk("serial_cmd", 4'hc, {command_strobe, command_code});
        remote_select = 1'b0;
        panel_model_inst.send(console_pkg::ASCII_H);
        chk("serial_ignored", 3'h4, control_code);
    endtask
    task automatic t_clear();
        panel_model_inst.press(16'h0000, 8'h04);
        panel_model_inst.press(16'h0008, 8'h00);
        clear_cnt = 0;
        master_clear_key = 1'b1;
        @(negedge ref_clk);
        panel_model_inst.press(16'h0000, 8'h80);
        chk("no_strobe", 1'b0, command_strobe);
        master_clear_key = 1'b0;
        repeat (12) @(negedge ref_clk);
        chk("clear_len", 8, clear_cnt);
        cmd(5, 32'h7, 1);
    endtask
    task automatic t_break();
        cmd(5, 32'h1234, 4);
        cmd(2, 32'h0001_0000, 8);
        macro_address = 16'h1235;
        ref_instruction = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("no_match", 1'b0, break_stop);
        macro_address = 16'h1234;
        repeat (3) @(negedge ref_clk);
        chk("macro_stop", 1'b1, break_stop);
        int_cnt = 0;
        cmd(2, 32'h0005_0000, 8);
        // Old stop is still latched; a later strobe clears it while hits now interrupt
        cmd(5, 32'h1234, 4);
        repeat (3) @(negedge ref_clk);
        chk("int_not_stop", 2'h1, {break_stop, int_cnt != 0});
        cmd(2, 32'h0009_0000, 8);
        repeat (3) @(negedge ref_clk);
        chk("micro_no_macro", 1'b0, break_stop);
        ref_instruction = 1'b0;
        micro_break_hit = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("micro_stop", 1'b1, break_stop);
        micro_break_hit = 1'b0;
    endtask
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        t_fc();
        t_display();
        t_remote();
        t_clear();
        t_break();
        final_report();
    end
endmodule
